/* File: design/ldpc_pkg.sv */
// Constants and types for the LED dimming PWM and phase controller.
// Assumes a 40 MHz reference clock and a 20 MHz dimming time base.
package ldpc_pkg;
    // Clock and time base
    localparam int REF_CLK_HZ = 40_000_000;
    localparam int OSC_HZ     = 20_000_000;
    localparam int TICK_DIV   = REF_CLK_HZ / OSC_HZ;
    localparam logic [1:0] TICK_LAST = 2'(TICK_DIV - 1);
    localparam int OSC_PERIOD_NS = 1_000_000_000 / OSC_HZ;
    localparam int MIN_PULSE_NS  = 200;
    localparam int MIN_PULSE_TICKS =
        (MIN_PULSE_NS + OSC_PERIOD_NS - 1) / OSC_PERIOD_NS;
    localparam int OSC_TICKS_PER_MS = OSC_HZ / 1000;
    // Dimming period: 2^(17 - code) ticks, code 0 is the slowest
    localparam int PER_W   = 18;
    localparam int PER_LOG = 17;
    // Channel current levels
    localparam int CHANNELS = 4;
    localparam logic [11:0] LEVEL_FULL    = 12'hFFF;
    localparam int          HYB_SHIFT     = 3;
    localparam logic [11:0] HYB_LOW_LEVEL = 12'h200;
    localparam logic [15:0] HYB_THRESHOLD = 16'h2000;
    // Brightness smoothing and dither
    localparam int          SLOPE_STEP_LOG = 8;
    localparam int          ENH_TAIL_LOG   = 4;
    localparam logic [2:0]  DITHER_MAX     = 3'h4;
    // Register indices on the register access port
    localparam logic [3:0] ADDR_LEVEL0 = 4'h0;
    localparam logic [3:0] ADDR_BRIGHT = 4'h4;
    localparam logic [3:0] ADDR_CTRL   = 4'h5;
    localparam logic [3:0] ADDR_STATUS = 4'h6;
    localparam logic [3:0] ADDR_DUTY   = 4'h7;
    // Control register fields
    localparam int CTRL_SRC_BIT   = 0;
    localparam int CTRL_SLOPE_LSB = 1;
    localparam int CTRL_ENH_BIT   = 4;
    localparam int CTRL_DITH_LSB  = 5;
    localparam int CTRL_HYB0_BIT  = 8;
    localparam logic [15:0] CTRL_RESET  = 16'h001A;
    localparam logic [15:0] CTRL_MASK   = 16'h01FF;
    localparam logic [15:0] BRIGHT_RESET = 16'h0000;
    // Target addresses picked by the mode strap
    localparam logic [6:0] I2C_ADDR_DEF = 7'h3B;
    localparam logic [6:0] I2C_ADDR_ALT = 7'h3A;

    // String configurations
    typedef enum logic [2:0] {
        STR_FOUR  = 3'b000,
        STR_THREE = 3'b001,
        STR_TWO   = 3'b010,
        STR_PAIRS = 3'b011,
        STR_ONE   = 3'b100
    } ldpc_string_t;

    // Dimming modes
    typedef enum logic [1:0] {
        MODE_PSPWM   = 2'b00,
        MODE_HYBRID  = 2'b01,
        MODE_CURRENT = 2'b10,
        MODE_DIRECT  = 2'b11
    } ldpc_mode_t;
endpackage : ldpc_pkg

/* File: design/ldpc_duty_meter.sv */
// Measures the duty cycle of the host PWM input pin as a 16-bit value.
// Assumes the pin is synchronous to ref_clk; counts on the 20 MHz tick.
`timescale 1ns/1ps
module ldpc_duty_meter
    import ldpc_pkg::*;
(
    // Clock, reset and time base
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic        tick,
    // Host PWM pin and result
    input  wire logic        pwm_pin,
    output logic [15:0]      duty
);
    localparam int CW = 24;
    logic [CW-1:0] hi_cnt, per_cnt, den;
    logic [CW:0]   rem;
    logic [16:0]   quo;
    logic [4:0]    bits;
    logic          pin_prev, busy;

    // Rising edge closes one input period
    wire rise    = tick && pwm_pin && !pin_prev;
    wire per_sat = &per_cnt;
    wire ge      = rem >= {1'b0, den};
    wire [CW:0] rem_sub = ge ? rem - {1'b0, den} : rem;

    // Counters, then a bit-serial divide of high time by period
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            hi_cnt <= '0;
            per_cnt <= '0;
            pin_prev <= 1'b0;
            busy <= 1'b0;
            den <= '0;
            rem <= '0;
            quo <= '0;
            bits <= 5'h00;
            duty <= 16'h0000;
        end else begin
            if (tick) begin
                pin_prev <= pwm_pin;
            end
            if (rise && !busy && per_cnt != '0) begin
                busy <= 1'b1;
                den <= per_cnt;
                rem <= {1'b0, hi_cnt};
                bits <= 5'h11;
                hi_cnt <= {{(CW-1){1'b0}}, 1'b1};
                per_cnt <= {{(CW-1){1'b0}}, 1'b1};
            end else if (tick && per_sat) begin
                // Stuck pin: report 0 % or 100 %
                duty <= pwm_pin ? 16'hFFFF : 16'h0000;
            end else if (tick) begin
                per_cnt <= per_cnt + 1'b1;
                hi_cnt <= hi_cnt + CW'(pwm_pin);
            end
            if (busy) begin
                quo <= {quo[15:0], ge};
                rem <= {rem_sub[CW-1:0], 1'b0};
                bits <= bits - 5'h01;
                if (bits == 5'h01) begin
                    busy <= 1'b0;
                    // Full period high saturates at 0xFFFF
                    duty <= (quo[15] || ge) && quo[15:0] == 16'hFFFF
                        ? 16'hFFFF : (quo[15] ? 16'hFFFF : {quo[14:0], ge});
                end
            end
        end
    end
endmodule // ldpc_duty_meter

/* File: design/ldpc_top.sv */
// LED dimming PWM generator with automatic phase shift for four sinks.
// Registers come from a serial-interface front end as word writes.
// Behaviour
// - Sink current code scales linearly with level; 4095 gives full.
// - Every channel level resets to 0xFFF.
// - String strap picks 4x90, 3x120, 2x180, pairs at 180 or one group.
// - Captured string setting holds until a pass through shutdown.
// - Channels of one group switch identically.
// - Phase-shift mode: groups run at dimming rate, fixed phase step.
// - Dimming period comes from 20 MHz base, free of input PWM rate.
// - All duty counting uses the 20 MHz tick.
// - Frequency strap picks one of eight rates, 152 to 19531 Hz.
// - Duty resolution 16 bits at two slowest rates, down to 10 bits.
// - Source select picks input pin duty or brightness register.
// - Smoothing on by default; smoothing and dither are programmable.
// - Mode strap picks dimming mode and target address 0x3B or 0x3A.
// - Phase-shift and hybrid rates come from the internal base.
// - Hybrid: PWM at low brightness, current dimming above; 8x range.
// - Hybrid changeover at 12.5 percent, or 0 for pure current.
// - Direct mode: active sinks follow the input pin.
// - Slope code 000 disables smoothing; default 200 ms, enhanced.
// - Dither of 0 to 4 bits, off by default.
// - n-bit dither stretches value-many pulses per 2^n periods.
// - Pulses under 200 ns are skipped, never below 152 Hz.
`timescale 1ns/1ps
module ldpc_top
    import ldpc_pkg::*;
#(
    parameter int SLOPE_MS_TICKS = OSC_TICKS_PER_MS
) (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    // Power state and straps
    input  wire logic        shutdown,
    input  wire logic [2:0]  string_config_strap,
    input  wire logic [2:0]  dimming_freq_strap,
    input  wire logic [2:0]  mode_strap,
    // Host PWM input
    input  wire logic        pwm_in,
    // Register access port
    input  wire logic        reg_wr_en,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    output logic [15:0]      reg_rdata,
    // Sink channels and target address
    output logic [3:0]       sink_channel_pin,
    output logic [47:0]      channel_current_code,
    output logic [6:0]       i2c_target_addr
);
    // Group index of a channel
    function automatic logic [1:0] group_of(ldpc_string_t s, int ch);
        logic [1:0] g;
        g = 2'(ch);
        if (s == STR_PAIRS) g = 2'(ch / 2);
        if (s == STR_ONE) g = 2'h0;
        return g;
    endfunction

    // Number of separately phased groups
    function automatic logic [2:0] groups_of(ldpc_string_t s);
        logic [2:0] n;
        n = 3'h4;
        if (s == STR_THREE) n = 3'h3;
        if (s == STR_TWO || s == STR_PAIRS) n = 3'h2;
        if (s == STR_ONE) n = 3'h1;
        return n;
    endfunction

    // Sinks in use; unused pins are grounded on the board
    function automatic logic [3:0] active_of(ldpc_string_t s);
        logic [3:0] m;
        m = 4'hF;
        if (s == STR_THREE) m = 4'h7;
        if (s == STR_TWO) m = 4'h3;
        return m;
    endfunction

    // Out-of-table strap codes fall back to four strings
    function automatic ldpc_string_t decode_string(logic [2:0] c);
        return c > STR_ONE ? STR_FOUR : ldpc_string_t'(c);
    endfunction

    // Smoothing time per slope code, in ms
    function automatic logic [9:0] slope_ms(logic [2:0] c);
        logic [9:0] t;
        unique case (c)
            3'h0: t = 10'd0;
            3'h1: t = 10'd1;
            3'h2: t = 10'd2;
            3'h3: t = 10'd50;
            3'h4: t = 10'd100;
            3'h5: t = 10'd200;
            3'h6: t = 10'd300;
            3'h7: t = 10'd500;
        endcase
        return t;
    endfunction

    // Linear current scaling, exact at full scale
    function automatic logic [11:0] cur_scale(logic [11:0] lv,
                                             logic [11:0] f);
        logic [23:0] p;
        p = lv * f;
        return 12'(p / 24'(LEVEL_FULL));
    endfunction

    // Phase offset of a group: g * period / n
    function automatic logic [PER_W-1:0] phase_off(logic [1:0] g,
        logic [2:0] n, logic [PER_W-1:0] per);
        logic [PER_W+1:0] p;
        p = (PER_W+2)'(g) * (PER_W+2)'(per);
        return PER_W'(p / (PER_W+2)'(n));
    endfunction

    // 20 MHz time base as an enable pulse
    logic [1:0] tick_cnt;
    logic       tick;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt <= 2'h0;
            tick <= 1'b0;
        end else begin
            tick_cnt <= tick_cnt == TICK_LAST ? 2'h0 : tick_cnt + 2'h1;
            tick <= tick_cnt == TICK_LAST;
        end
    end

    // Straps are caught once per power-up, after reset or shutdown
    logic         strap_valid;
    ldpc_string_t cfg_string;
    logic [2:0]   cfg_freq;
    ldpc_mode_t   cfg_mode;
    logic         cfg_addr_sel;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            strap_valid <= 1'b0;
            cfg_string <= STR_FOUR;
            cfg_freq <= 3'h0;
            cfg_mode <= MODE_PSPWM;
            cfg_addr_sel <= 1'b0;
        end else if (shutdown) begin
            strap_valid <= 1'b0;
        end else if (!strap_valid) begin
            strap_valid <= 1'b1;
            cfg_string <= decode_string(string_config_strap);
            cfg_freq <= dimming_freq_strap;
            cfg_mode <= ldpc_mode_t'(mode_strap[1:0]);
            cfg_addr_sel <= mode_strap[2];
        end
    end

    // Software registers
    logic [11:0] level [CHANNELS];
    logic [15:0] disp_bright;
    logic [15:0] ctrl;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < CHANNELS; i++) begin
                level[i] <= LEVEL_FULL;
            end
            disp_bright <= BRIGHT_RESET;
            ctrl <= CTRL_RESET;
        end else if (reg_wr_en) begin
            for (int i = 0; i < CHANNELS; i++) begin
                if (reg_addr == ADDR_LEVEL0 + 4'(i)) level[i] <= reg_wdata[11:0];
            end
            if (reg_addr == ADDR_BRIGHT) disp_bright <= reg_wdata;
            if (reg_addr == ADDR_CTRL) ctrl <= reg_wdata & CTRL_MASK;
        end
    end

    // Control fields
    wire       src_reg   = ctrl[CTRL_SRC_BIT];
    wire [2:0] slope_sel = ctrl[CTRL_SLOPE_LSB +: 3];
    wire       enh_en    = ctrl[CTRL_ENH_BIT];
    wire [2:0] dith_sel  = ctrl[CTRL_DITH_LSB +: 3];
    wire       hyb_zero  = ctrl[CTRL_HYB0_BIT];
    wire [3:0] active    = active_of(cfg_string);

    // Input pin duty measurement
    logic [15:0] meas_duty;
    ldpc_duty_meter u_meter (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .tick    (tick),
        .pwm_pin (pwm_in),
        .duty    (meas_duty)
    );

    // Brightness source and linear smoothing
    wire [15:0] target = src_reg ? disp_bright : meas_duty;
    logic [15:0] bright_cur, target_prev, step;
    logic [31:0] slope_cnt;
    wire [31:0] slope_iv =
        32'((32'(slope_ms(slope_sel)) * 32'(SLOPE_MS_TICKS)) >> SLOPE_STEP_LOG);
    wire [15:0] remain = target > bright_cur ? target - bright_cur
                                             : bright_cur - target;
    wire [15:0] span_step = (remain >> SLOPE_STEP_LOG) == 16'h0000
                            ? 16'h0001 : remain >> SLOPE_STEP_LOG;
    // Enhanced smoothing halves the step over the last stretch
    wire tail = 20'(remain) < (20'(step) << ENH_TAIL_LOG);
    wire [15:0] eff_step = enh_en && tail && step > 16'h0001 ? step >> 1 : step;
    wire [15:0] next_bright = remain <= eff_step ? target
        : target > bright_cur ? bright_cur + eff_step : bright_cur - eff_step;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            bright_cur <= 16'h0000;
            target_prev <= 16'h0000;
            step <= 16'h0001;
            slope_cnt <= 32'h0000_0000;
        end else begin
            target_prev <= target;
            if (target != target_prev) step <= span_step;
            if (slope_sel == 3'h0) begin
                bright_cur <= target;
                slope_cnt <= 32'h0000_0000;
            end else if (tick && slope_cnt + 32'h1 >= slope_iv) begin
                bright_cur <= next_bright;
                slope_cnt <= 32'h0000_0000;
            end else if (tick) begin
                slope_cnt <= slope_cnt + 32'h1;
            end
        end
    end

    // Mode split into PWM duty and current factor
    wire below_thr = bright_cur < HYB_THRESHOLD;
    wire hyb_low   = cfg_mode == MODE_HYBRID && !hyb_zero && below_thr;
    wire duty_full = cfg_mode == MODE_CURRENT
                  || (cfg_mode == MODE_HYBRID && !hyb_low);
    wire [15:0] pwm_duty = hyb_low ? 16'(bright_cur << HYB_SHIFT)
                                   : bright_cur;
    wire [11:0] cur_factor = cfg_mode == MODE_PSPWM ? LEVEL_FULL
        : cfg_mode == MODE_DIRECT ? LEVEL_FULL
        : hyb_low ? HYB_LOW_LEVEL : bright_cur[15:4];

    // Dimming period counter, free of the input pin rate
    logic [PER_W-1:0] cnt, len_q, acc;
    logic [3:0]       seq;
    logic [7:0]       skip_cnt;
    wire [PER_W-1:0] period = PER_W'(1) << (PER_LOG - 32'(cfg_freq));
    wire period_end = tick && cnt >= period - 1'b1;

    // Duty to ticks: 16 bits at the two slowest rates, then one less
    wire [20:0] duty_ext = {pwm_duty, 5'h00} >> cfg_freq;
    wire [PER_W-1:0] on_base = {1'b0, duty_ext[20:4]};
    wire [2:0] dith_n = dith_sel > DITHER_MAX ? DITHER_MAX : dith_sel;
    wire [3:0] dith_val = duty_ext[3:0] >> (3'h4 - dith_n);
    wire [3:0] dith_mask = 4'((5'h01 << dith_n) - 5'h01);
    wire stretch = dith_n != 3'h0 && (seq & dith_mask) < dith_val;
    wire [PER_W-1:0] want = on_base + PER_W'(stretch);

    // Short pulses are pooled; at least one pulse per slowest period
    wire [PER_W-1:0] acc_sum = acc + want;
    wire [7:0] skip_max = 8'((9'h001 << cfg_freq) - 9'h001);
    wire short_pulse = !duty_full && want != '0 && want < PER_W'(MIN_PULSE_TICKS);
    wire fire_short = acc_sum >= PER_W'(MIN_PULSE_TICKS)
                   || skip_cnt >= skip_max;
    wire [PER_W-1:0] next_len = duty_full ? period : !short_pulse ? want
                              : fire_short ? acc_sum : '0;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= '0;
            len_q <= '0;
            acc <= '0;
            seq <= 4'h0;
            skip_cnt <= 8'h00;
        end else if (period_end) begin
            cnt <= '0;
            len_q <= next_len;
            seq <= seq + 4'h1;
            acc <= short_pulse && !fire_short ? acc_sum : '0;
            skip_cnt <= short_pulse && !fire_short ? skip_cnt + 8'h01 : 8'h00;
        end else if (tick) begin
            cnt <= cnt + 1'b1;
        end
    end

    // Per-channel phase and switching
    logic       pwm_q;
    logic [3:0] next_sink;
    logic [11:0] next_code [CHANNELS];
    for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_ch
        wire [PER_W-1:0] off = phase_off(group_of(cfg_string, ch),
                                         groups_of(cfg_string), period);
        wire [PER_W-1:0] rel = cnt >= off ? cnt - off : cnt + period - off;
        wire pulse_on  = tick && rel == '0 && len_q != '0;
        wire pulse_off = tick && rel >= len_q;
        assign next_sink[ch] = !strap_valid || !active[ch] ? 1'b0
            : cfg_mode == MODE_DIRECT ? pwm_q
            : pulse_on ? 1'b1
            : pulse_off ? 1'b0 : sink_channel_pin[ch];
        assign next_code[ch] = active[ch] ? cur_scale(level[ch], cur_factor)
                                          : 12'h000;
    end

    // Read-back selection
    wire [15:0] status_word = {6'h00, strap_valid, cfg_addr_sel, cfg_freq,
                               cfg_string, cfg_mode};
    wire [15:0] next_rdata = reg_addr < ADDR_BRIGHT ? {4'h0, level[reg_addr[1:0]]}
        : reg_addr == ADDR_BRIGHT ? disp_bright
        : reg_addr == ADDR_CTRL ? ctrl
        : reg_addr == ADDR_STATUS ? status_word
        : reg_addr == ADDR_DUTY ? bright_cur : 16'h0000;

    // Output registers
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pwm_q <= 1'b0;
            sink_channel_pin <= 4'h0;
            channel_current_code <= {4{LEVEL_FULL}};
            i2c_target_addr <= I2C_ADDR_DEF;
            reg_rdata <= 16'h0000;
        end else begin
            pwm_q <= pwm_in;
            sink_channel_pin <= next_sink;
            channel_current_code <= {next_code[3], next_code[2],
                                     next_code[1], next_code[0]};
            i2c_target_addr <= cfg_addr_sel ? I2C_ADDR_ALT : I2C_ADDR_DEF;
            reg_rdata <= next_rdata;
        end
    end

    // Checks
    wire [11:0] level0 = level[0];
    a_strap_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
        strap_valid && $past(strap_valid) && !shutdown
        |-> $stable(cfg_string) && $stable(cfg_mode) && $stable(cfg_freq))
        else $error("strap setting changed while running");
    a_level_full: assert property (@(posedge ref_clk) disable iff (!rst_n)
        strap_valid && cfg_mode == MODE_PSPWM && active[0]
        |=> channel_current_code[11:0] == $past(level0))
        else $error("full-scale current code differs from level");
    a_pairs_same: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $past(cfg_string) == STR_PAIRS && $past(strap_valid)
        |-> sink_channel_pin[0] == sink_channel_pin[1]
            && sink_channel_pin[2] == sink_channel_pin[3])
        else $error("grouped sinks disagree");
    a_unused_dark: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $past(cfg_string) == STR_THREE |-> !sink_channel_pin[3])
        else $error("unused sink switched on");
    a_tick_rate: assert property (@(posedge ref_clk) disable iff (!rst_n)
        tick |=> !tick ##1 tick)
        else $error("time base not at half the reference rate");
    a_period_wrap: assert property (@(posedge ref_clk) disable iff (!rst_n)
        period_end |=> cnt == '0 ##1 cnt == '0 ##1 cnt == PER_W'(1))
        else $error("dimming period counter did not restart");
    a_direct_follow: assert property (@(posedge ref_clk) disable iff (!rst_n)
        strap_valid && cfg_mode == MODE_DIRECT && active[0] && $stable(cfg_mode)
        |=> sink_channel_pin[0] == $past(pwm_in, 2))
        else $error("direct mode sink not following input");
    a_hybrid_low: assert property (@(posedge ref_clk) disable iff (!rst_n)
        cfg_mode == MODE_HYBRID && !hyb_zero && below_thr
        |-> cur_factor == HYB_LOW_LEVEL && !duty_full
            && pwm_duty == 16'(bright_cur << HYB_SHIFT))
        else $error("hybrid low range not PWM at reduced current");
    a_hybrid_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
        cfg_mode == MODE_HYBRID && hyb_zero
        |-> duty_full && cur_factor == bright_cur[15:4])
        else $error("zero changeover not pure current dimming");
    a_dither_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
        dith_sel == 3'h0 |-> !stretch)
        else $error("pulse stretched with dither off");
    a_slope_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
        slope_sel == 3'h0 |=> bright_cur == $past(target))
        else $error("brightness lagged with smoothing off");
    a_min_skip: assert property (@(posedge ref_clk) disable iff (!rst_n)
        period_end && short_pulse && !fire_short |=> len_q == '0)
        else $error("short pulse was not skipped");
endmodule // ldpc_top

/* File: tb/ldpc_host_model.sv */
// Host side model: drives the PWM input pin of the dimming block.
// Assumes one clock; pin changes just after a rising edge.
`timescale 1ns/1ps
module ldpc_host_model (
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    // Duty request and pin
    input  wire logic [7:0] high_cnt,
    output logic            pwm_in
);
    logic [7:0] cnt;
    // 256-cycle frame, high while cnt below high_cnt; rate unrelated to dimming
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt    <= 8'h00;
            pwm_in <= 1'b0;
        end else begin
            cnt    <= cnt + 8'h01;
            pwm_in <= (cnt < high_cnt);
        end
    end
endmodule // ldpc_host_model

/* File: tb/ldpc_bench.sv */
// Self-checking bench: model of levels, straps and modes against ldpc_top.
// Assumes ldpc_pkg and the host model are compiled first.
`timescale 1ns/1ps
module led_dimming_pwm_phase_controller_bench;
    import ldpc_pkg::*;
    logic ref_clk = 0, rst_n = 0, shutdown = 0, reg_wr_en = 0, pwm_in;
    logic [2:0] string_config_strap = 3'h0, dimming_freq_strap = 3'h7, mode_strap = 3'h0;
    logic [3:0] reg_addr = 4'h0, sink_channel_pin;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata, rv, b;
    logic [7:0] high_cnt = 8'h05;
    logic [47:0] channel_current_code;
    logic [6:0] i2c_target_addr;
    logic [11:0] lvl [4];
    logic [11:0] n0, n1;
    logic q [$];
    int error_cnt = 0, check_count = 0, cyc = 0, s;
    always #12.5 ref_clk = ~ref_clk;
    ldpc_top #(.SLOPE_MS_TICKS(80)) i_ldpc_top (.ref_clk(ref_clk), .rst_n(rst_n), .shutdown(shutdown),
        .string_config_strap(string_config_strap), .dimming_freq_strap(dimming_freq_strap),
        .mode_strap(mode_strap), .pwm_in(pwm_in), .reg_wr_en(reg_wr_en), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .sink_channel_pin(sink_channel_pin),
        .channel_current_code(channel_current_code), .i2c_target_addr(i2c_target_addr));
    ldpc_host_model i_ldpc_host_model (.ref_clk(ref_clk), .rst_n(rst_n), .high_cnt(high_cnt), .pwm_in(pwm_in));
    task automatic check(input logic [47:0] seen, input logic [47:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        if (error_cnt == 0 && check_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge ref_clk); reg_wr_en <= 1'b1; reg_addr <= a; reg_wdata <= d;
        @(posedge ref_clk); reg_wr_en <= 1'b0;
    endtask
    // Read data lands one cycle after the index is sampled
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge ref_clk); reg_addr <= a;
        @(posedge ref_clk); @(posedge ref_clk); #1 d = reg_rdata;
    endtask
    // Straps are only taken again after a pass through shutdown
    task automatic restrap(input logic [2:0] sc, input logic [2:0] m);
        @(posedge ref_clk); shutdown <= 1'b1; string_config_strap <= sc; mode_strap <= m;
        repeat (2) @(posedge ref_clk); shutdown <= 1'b0;
        repeat (5) @(posedge ref_clk); #1;
    endtask
    // Reference current codes per channel, unused channels zero
    function automatic logic [47:0] exp_codes(input int m, input int sc, input int br);
        logic [47:0] r;
        int act, fac;
        act = (sc == 1) ? 3 : (sc == 2) ? 2 : 4;
        fac = (m == 2) ? br >> 4 : (m == 1) ? ((br < 'h2000) ? 'h200 : br >> 4) : 4095;
        for (int i = 0; i < 4; i++) r[i*12+:12] = (i < act) ? 12'(lvl[i] * fac / 4095) : 12'h000;
        return r;
    endfunction
    // Hang guard, near three times the roughly 7000 cycles the sequence needs
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            report_and_stop();
        end
    end
    initial begin
        void'($urandom(32'h6756));
        repeat (3) @(posedge ref_clk);
        check({channel_current_code}, {4{12'hFFF}});
        check({i2c_target_addr, sink_channel_pin}, {7'h3B, 4'h0});
        rst_n <= 1'b1;
        rd(ADDR_CTRL, rv); check(rv, CTRL_RESET);
        rd(ADDR_LEVEL0, rv); check(rv, 16'h0FFF);
        for (int i = 0; i < 4; i++) begin
            lvl[i] = 12'($urandom);
            wr(4'(i), {4'h0, lvl[i]});
            rd(4'(i), rv); check(rv, {4'h0, lvl[i]});
        end
        rd(4'h9, rv); check(rv, 16'h0000);
        wr(ADDR_CTRL, 16'h0001);
        // Every mode, address and frequency strap; hybrid once below its threshold
        for (int m = 0; m < 8; m++) begin
            s = m % 5;
            b = 16'($urandom) >> ((m == 1) ? 3 : 0);
            wr(ADDR_BRIGHT, b);
            dimming_freq_strap <= 3'(m);
            restrap(3'(s), 3'(m));
            check(channel_current_code, exp_codes(m % 4, s, b));
            check(i2c_target_addr, (m > 3) ? 7'h3A : 7'h3B);
            rd(ADDR_STATUS, rv); check(rv[9:0], {1'b1, 1'(m / 4), 3'(m), 3'(s), 2'(m)});
        end
        // Strap moves while running; the captured setting must not
        string_config_strap <= 3'h4;
        rd(ADDR_STATUS, rv); check(rv[4:2], 3'h2);
        // Phase-shift, four strings, half duty at 1024 ticks a period
        restrap(3'h0, 3'h0);
        wr(ADDR_BRIGHT, 16'h8000);
        repeat (4200) @(posedge ref_clk);
        n0 = 12'h000;
        n1 = 12'h000;
        repeat (2048) begin
            @(negedge ref_clk);
            n0 += 12'(sink_channel_pin[0]);
            n1 += 12'(sink_channel_pin[0] && !sink_channel_pin[1]);
        end
        check(n0, 12'h400);
        check(n1, 12'h200);
        // Changeover at zero: hybrid is pure current dimming, dither at its cap
        restrap(3'h4, 3'h1);
        wr(ADDR_CTRL, 16'h01E1);
        b = 16'($urandom) >> 3;
        wr(ADDR_BRIGHT, b);
        repeat (3) @(posedge ref_clk);
        #1;
        check(channel_current_code, exp_codes(2, 4, b));
        rd(ADDR_CTRL, rv); check(rv, 16'h01E1);
        restrap(3'h3, 3'h3);
        for (int k = 0; k < 600; k++) begin
            @(negedge ref_clk);
            if (k % 150 == 0) high_cnt <= 8'($urandom);
            q.push_back(pwm_in);
            if (k > 2) check(sink_channel_pin, {4{q[k-2]}});
        end
        report_and_stop();
    end
endmodule // led_dimming_pwm_phase_controller_bench
